// *** hdl/dop_pkg.sv ***
// Constants shared by the deserializer output port and its line buffer
package dop_pkg;

  // ***************************************************************
  // Widths and buffer shape
  // ***************************************************************
  localparam int DOP_WORD_W = 10;
  localparam int DOP_ADDR_W = 4;
  localparam int DOP_DEPTH = 16;
  localparam int DOP_PTR_W = DOP_ADDR_W + 1;
  localparam int DOP_STAT_N = 4;
  localparam int DOP_SEL_W = 3;
  localparam int DOP_SRC_N = 8;

  // ***************************************************************
  // Line buffer modes (configuration code)
  // ***************************************************************
  localparam logic [1:0] DOP_FMODE_VIDEO = 2'h0;
  localparam logic [1:0] DOP_FMODE_ASI = 2'h1;
  localparam logic [1:0] DOP_FMODE_ANC = 2'h2;
  localparam logic [1:0] DOP_FMODE_DELAY = 2'h3;

  // ***************************************************************
  // Status source selector codes
  // ***************************************************************
  localparam logic [2:0] DOP_SRC_H = 3'h0;
  localparam logic [2:0] DOP_SRC_V = 3'h1;
  localparam logic [2:0] DOP_SRC_F = 3'h2;
  localparam logic [2:0] DOP_SRC_LOAD = 3'h3;
  localparam logic [2:0] DOP_SRC_ANC = 3'h4;
  localparam logic [2:0] DOP_SRC_ERR = 3'h5;
  localparam logic [2:0] DOP_SRC_FULL = 3'h6;
  localparam logic [2:0] DOP_SRC_EMPTY = 3'h7;

  // Default selector sets, stat3 in the top field
  localparam logic [11:0] DOP_DEF_BYPASS = {DOP_SRC_ANC, DOP_SRC_F, DOP_SRC_V, DOP_SRC_H};
  localparam logic [11:0] DOP_DEF_VIDEO = {DOP_SRC_LOAD, DOP_SRC_F, DOP_SRC_V, DOP_SRC_H};
  localparam logic [11:0] DOP_DEF_ASI = {DOP_SRC_ERR, DOP_SRC_LOAD, DOP_SRC_EMPTY, DOP_SRC_FULL};
  localparam logic [11:0] DOP_DEF_ANC = {DOP_SRC_ERR, DOP_SRC_ANC, DOP_SRC_V, DOP_SRC_H};

  // ***************************************************************
  // Synchroniser lanes
  // ***************************************************************
  localparam int DOP_SYN_N = 7;
  localparam int DOP_SYN_AUTO = 0;
  localparam int DOP_SYN_ASI = 1;
  localparam int DOP_SYN_BYP = 2;
  localparam int DOP_SYN_FEN = 3;
  localparam int DOP_SYN_RCLK = 4;
  localparam int DOP_SYN_RRST = 5;
  localparam int DOP_SYN_PCLK = 6;

endpackage

// *** hdl/dop_fifo_mem.sv ***
// Small line buffer memory with registered read data and pointer reset
`timescale 1ns/1ps
module dop_fifo_mem
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic [dop_pkg::DOP_WORD_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic i_ptr_clear,
  output logic [dop_pkg::DOP_WORD_W-1:0] o_rd_data,
  output logic o_full,
  output logic o_empty
);
  import dop_pkg::*;

  logic [DOP_WORD_W-1:0] mem_reg [DOP_DEPTH];
  logic [DOP_PTR_W-1:0] wr_ptr_reg;
  logic [DOP_PTR_W-1:0] rd_ptr_reg;
  logic wr_ok;
  logic rd_ok;

  // Full and empty from the wrap bit of the pointers
  assign o_empty = (wr_ptr_reg == rd_ptr_reg);
  assign o_full = (wr_ptr_reg[DOP_ADDR_W] != rd_ptr_reg[DOP_ADDR_W]) &&
                  (wr_ptr_reg[DOP_ADDR_W-1:0] == rd_ptr_reg[DOP_ADDR_W-1:0]);
  assign wr_ok = i_wr_en && !o_full;
  assign rd_ok = i_rd_en && !o_empty;

  // Storage has no reset; writes into a full buffer are dropped
  always_ff @(posedge i_mclk)
  begin
    if (wr_ok)
    begin
      mem_reg[wr_ptr_reg[DOP_ADDR_W-1:0]] <= i_wr_data;
    end
  end

  // Write pointer
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      wr_ptr_reg <= '0;
    else if (wr_ok)
      wr_ptr_reg <= wr_ptr_reg + DOP_PTR_W'(1);
  end

  // Read pointer; a clear beats a read in the same cycle
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rd_ptr_reg <= '0;
    else if (i_ptr_clear)
      rd_ptr_reg <= '0;
    else if (rd_ok)
      rd_ptr_reg <= rd_ptr_reg + DOP_PTR_W'(1);
  end

  // Registered read word
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rd_data <= '0;
    else if (rd_ok)
      o_rd_data <= mem_reg[rd_ptr_reg[DOP_ADDR_W-1:0]];
  end

endmodule

// *** hdl/dop_output_port.sv ***
// Parallel output, status and mode pin side of the deserializer
`timescale 1ns/1ps
module dop_output_port
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_auto_manual_select,
  input wire logic i_transport_mode_pin,
  output logic o_transport_mode_pin,
  output logic o_transport_mode_pin_oe,
  input wire logic i_video_path_select_pin,
  output logic o_video_path_select_pin,
  output logic o_video_path_select_pin_oe,
  input wire logic i_fifo_enable,
  input wire logic [1:0] i_fifo_mode,
  input wire logic i_read_clock,
  input wire logic i_read_reset,
  input wire logic i_recovered_clock,
  input wire logic i_video_lock,
  input wire logic i_transport_lock,
  input wire logic i_reclock_lock,
  input wire logic [dop_pkg::DOP_WORD_W-1:0] i_pixel_word,
  input wire logic i_buf_wr_en,
  input wire logic [dop_pkg::DOP_WORD_W-1:0] i_buf_wr_data,
  input wire logic i_hsync,
  input wire logic i_vsync,
  input wire logic i_field,
  input wire logic i_line_buffer_load_pulse,
  input wire logic i_ancillary_packet_seen,
  input wire logic i_error_packet_seen,
  input wire logic i_stat_programmed,
  input wire logic [dop_pkg::DOP_STAT_N*dop_pkg::DOP_SEL_W-1:0] i_stat_select,
  output logic o_buf_full,
  output logic o_buf_empty,
  output logic [dop_pkg::DOP_WORD_W-1:0] o_dout,
  output logic [dop_pkg::DOP_STAT_N-1:0] o_stat,
  output logic o_pixel_clock,
  output logic o_locked
);
  import dop_pkg::*;

  // ***************************************************************
  // Pin synchronisers and edge detection
  // ***************************************************************
  logic [DOP_SYN_N-1:0] sync1_reg;
  logic [DOP_SYN_N-1:0] sync2_reg;
  logic rclk_last_reg;
  logic pclk_last_reg;
  logic rrst_at_edge_reg;
  logic auto_mode;
  logic asi_in;
  logic byp_in;
  logic fifo_en;
  logic rd_edge;
  logic pix_edge;

  // All pin inputs pass two flops; only the second stage is read
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {i_recovered_clock, i_read_reset, i_read_clock, i_fifo_enable,
                    i_video_path_select_pin, i_transport_mode_pin, i_auto_manual_select};
      sync2_reg <= sync1_reg;
    end
  end

  assign auto_mode = sync2_reg[DOP_SYN_AUTO];
  assign asi_in = sync2_reg[DOP_SYN_ASI];
  assign byp_in = sync2_reg[DOP_SYN_BYP];
  assign fifo_en = sync2_reg[DOP_SYN_FEN];
  assign rd_edge = sync2_reg[DOP_SYN_RCLK] && !rclk_last_reg;
  assign pix_edge = sync2_reg[DOP_SYN_PCLK] && !pclk_last_reg;

  // Edge history, and the read reset level seen at each read clock edge
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rclk_last_reg <= 1'b0;
      pclk_last_reg <= 1'b0;
      rrst_at_edge_reg <= 1'b0;
    end
    else
    begin
      rclk_last_reg <= sync2_reg[DOP_SYN_RCLK];
      pclk_last_reg <= sync2_reg[DOP_SYN_PCLK];
      if (rd_edge)
        rrst_at_edge_reg <= sync2_reg[DOP_SYN_RRST];
    end
  end

  // ***************************************************************
  // Operating mode and lock
  // ***************************************************************
  logic asi_mode;
  logic video_mode;
  logic locked_next;
  logic locked_reg;

  // Manual transport high wins over the video pin
  assign asi_mode = auto_mode ? i_transport_lock : asi_in;
  assign video_mode = auto_mode ? (i_video_lock && !i_transport_lock)
                                : (!asi_in && byp_in);

  // Data-through only exists in manual mode with both pins low
  always_comb
  begin
    if (asi_mode)
      locked_next = i_transport_lock;
    else if (video_mode)
      locked_next = i_video_lock;
    else
      locked_next = !auto_mode && i_reclock_lock;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      locked_reg <= 1'b0;
    else
      locked_reg <= locked_next;
  end

  assign o_locked = locked_reg;

  // ***************************************************************
  // Mode pins
  // ***************************************************************
  logic pin_oe_reg;
  logic asi_pin_reg;
  logic byp_pin_reg;

  // Pins are driven only in automatic mode; low while unlocked
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_oe_reg <= 1'b0;
      asi_pin_reg <= 1'b0;
      byp_pin_reg <= 1'b0;
    end
    else
    begin
      pin_oe_reg <= auto_mode;
      asi_pin_reg <= locked_reg && i_transport_lock;
      byp_pin_reg <= locked_reg && i_video_lock && !i_transport_lock;
    end
  end

  assign o_transport_mode_pin = asi_pin_reg;
  assign o_transport_mode_pin_oe = pin_oe_reg;
  assign o_video_path_select_pin = byp_pin_reg;
  assign o_video_path_select_pin_oe = pin_oe_reg;

  // ***************************************************************
  // Line buffer and data path
  // ***************************************************************
  logic fifo_path;
  logic reset_allowed;
  logic ptr_clear_reg;
  logic take_d_reg;
  logic dout_load;
  logic [DOP_WORD_W-1:0] buf_word;
  logic [DOP_WORD_W-1:0] dout_reg;
  logic pclk_reg;

  assign fifo_path = fifo_en && ((i_fifo_mode == DOP_FMODE_VIDEO) ||
                                 (i_fifo_mode == DOP_FMODE_ASI));
  assign reset_allowed = video_mode && !asi_mode && fifo_en &&
                         (i_fifo_mode == DOP_FMODE_VIDEO);

  // Pointer clear one cycle after the falling edge is seen at a read edge
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ptr_clear_reg <= 1'b0;
      take_d_reg <= 1'b0;
    end
    else
    begin
      ptr_clear_reg <= rd_edge && rrst_at_edge_reg && !sync2_reg[DOP_SYN_RRST] &&
                       reset_allowed;
      take_d_reg <= rd_edge && fifo_path;
    end
  end

  dop_fifo_mem u_mem
  (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_wr_en(i_buf_wr_en),
    .i_wr_data(i_buf_wr_data),
    .i_rd_en(rd_edge && fifo_path),
    .i_ptr_clear(ptr_clear_reg),
    .o_rd_data(buf_word),
    .o_full(o_buf_full),
    .o_empty(o_buf_empty)
  );

  // Buffered words wait for the memory register, bypass words for the pixel edge
  assign dout_load = fifo_path ? take_d_reg : pix_edge;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      dout_reg <= '0;
    else if (!locked_reg)
      dout_reg <= '0;
    else if (dout_load)
      dout_reg <= fifo_path ? buf_word : i_pixel_word;
  end

  // Pixel clock follows the recovered clock, held low while unlocked
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pclk_reg <= 1'b0;
    else
      pclk_reg <= locked_reg && sync2_reg[DOP_SYN_PCLK];
  end

  assign o_dout = dout_reg;
  assign o_pixel_clock = pclk_reg;

  // ***************************************************************
  // Status outputs
  // ***************************************************************
  logic [DOP_SRC_N-1:0] src_vec;
  logic [DOP_STAT_N*DOP_SEL_W-1:0] sel_all;
  logic [DOP_STAT_N-1:0] stat_reg;

  assign src_vec = {o_buf_empty, o_buf_full, i_error_packet_seen, i_ancillary_packet_seen,
                    i_line_buffer_load_pulse, i_field, i_vsync, i_hsync};

  // Defaults track the buffer mode until software takes over
  always_comb
  begin
    if (i_stat_programmed)
      sel_all = i_stat_select;
    else if (!fifo_en)
      sel_all = DOP_DEF_BYPASS;
    else if (i_fifo_mode == DOP_FMODE_ASI || asi_mode)
      sel_all = DOP_DEF_ASI;
    else if (i_fifo_mode == DOP_FMODE_ANC)
      sel_all = DOP_DEF_ANC;
    else
      sel_all = DOP_DEF_VIDEO;
  end

  // One multiplexer and flop per status pin
  for (genvar g = 0; g < DOP_STAT_N; g++)
  begin : g_stat
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
      if (!i_reset_n)
        stat_reg[g] <= 1'b0;
      else
        stat_reg[g] <= locked_reg && src_vec[sel_all[g*DOP_SEL_W +: DOP_SEL_W]];
    end
  end

  assign o_stat = stat_reg;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  sequence s_high_at_edge;
    rd_edge && sync2_reg[DOP_SYN_RRST];
  endsequence

  sequence s_fall_at_edge;
    rd_edge && !sync2_reg[DOP_SYN_RRST] && reset_allowed && rrst_at_edge_reg;
  endsequence

  a_dout_forced_low: assert property (!o_locked |=> o_dout == '0)
    else $error("data bus not low while unlocked");
  a_stat_forced_low: assert property (!o_locked |=> o_stat == '0)
    else $error("status pins not low while unlocked");
  a_pclk_forced_low: assert property (!o_locked |=> !o_pixel_clock)
    else $error("pixel clock running while unlocked");
  a_pin_oe_auto: assert property (auto_mode |=> o_transport_mode_pin_oe &&
                                  o_video_path_select_pin_oe)
    else $error("mode pins not driven in automatic mode");
  a_asi_pin_low: assert property (!i_transport_lock |=> !o_transport_mode_pin)
    else $error("transport pin high without transport lock");
  a_clear_gated: assert property (ptr_clear_reg |-> $past(reset_allowed))
    else $error("pointer cleared outside video settings");
  a_clear_on_fall: assert property (s_fall_at_edge |=> ptr_clear_reg)
    else $error("falling read reset did not clear pointer");
  a_no_clear_high: assert property (s_high_at_edge |=> !ptr_clear_reg)
    else $error("pointer cleared while read reset high");
  a_dout_launch: assert property (o_locked && $past(o_locked) && !$past(dout_load)
                                  |-> $stable(o_dout))
    else $error("data bus changed without a launch edge");
  a_stat_default: assert property (locked_reg && !i_stat_programmed && !fifo_en
                                   |=> o_stat[0] == $past(i_hsync))
    else $error("bypass default status pin 0 wrong");
  a_lock_manual_dt: assert property (!auto_mode && !asi_in && !byp_in && !i_reclock_lock
                                     |=> !o_locked)
    else $error("locked without reclocker lock in data-through");

endmodule

// *** tb/dop_app_model.sv ***
// Application-side reader model: read clock, read reset, manual mode pins
`timescale 1ns/1ps
module dop_app_model
(
  input wire logic [dop_pkg::DOP_WORD_W-1:0] i_dout,
  output logic o_read_clock,
  output logic o_read_reset,
  output logic o_transport_drive,
  output logic o_video_drive,
  output logic [dop_pkg::DOP_WORD_W-1:0] o_taken
);
  import dop_pkg::*;
  // Read clock stands low between bursts, as a real reader leaves it
  initial
  begin
    o_read_clock = 1'b0;
    o_read_reset = 1'b0;
    o_transport_drive = 1'b0;
    o_video_drive = 1'b0;
    o_taken = '0;
  end
  // Reader takes the word present at each read clock rise
  always_ff @(posedge o_read_clock)
  begin
    o_taken <= i_dout;
  end
  // One 320 ns read period; reset level settles well before the rise
  task automatic read_edge(input logic rst);
  begin
    o_read_reset = rst;
    #40;
    o_read_clock = 1'b1;
    #160;
    o_read_clock = 1'b0;
    #120;
  end
  endtask
  // Levels only reach the wire while the device leaves the pins alone
  task automatic set_pins(input logic tp, input logic vp);
  begin
    o_transport_drive = tp;
    o_video_drive = vp;
  end
  endtask
endmodule

// *** tb/dop_output_port_tb_top.sv ***
// Self-checking bench for the deserializer output port
`timescale 1ns/1ps
module dop_output_port_tb_top;
  import dop_pkg::*;
  logic i_mclk, i_reset_n, auto_sel, fen, rec_clk, vlock, tlock, rlock, wr_en, prog;
  logic tp_out, tp_oe, vp_out, vp_oe, full, empty, pclk, locked, rd_clk, rd_rst, tp_drv, vp_drv;
  logic tp_wire, vp_wire;
  logic [1:0] fmode;
  logic [DOP_WORD_W-1:0] pix, wr_data, dout, taken;
  logic [5:0] src;
  logic [11:0] sel;
  logic [3:0] stat;
  int fails;
  int tests_run;
  // Wire level: the device wins while its enable is up
  assign tp_wire = tp_oe ? tp_out : tp_drv;
  assign vp_wire = vp_oe ? vp_out : vp_drv;

  dop_output_port dop_output_port_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_auto_manual_select(auto_sel), .i_transport_mode_pin(tp_wire),
    .o_transport_mode_pin(tp_out), .o_transport_mode_pin_oe(tp_oe),
    .i_video_path_select_pin(vp_wire), .o_video_path_select_pin(vp_out),
    .o_video_path_select_pin_oe(vp_oe), .i_fifo_enable(fen), .i_fifo_mode(fmode),
    .i_read_clock(rd_clk), .i_read_reset(rd_rst), .i_recovered_clock(rec_clk),
    .i_video_lock(vlock), .i_transport_lock(tlock), .i_reclock_lock(rlock),
    .i_pixel_word(pix), .i_buf_wr_en(wr_en), .i_buf_wr_data(wr_data), .i_hsync(src[0]),
    .i_vsync(src[1]), .i_field(src[2]), .i_line_buffer_load_pulse(src[3]),
    .i_ancillary_packet_seen(src[4]), .i_error_packet_seen(src[5]),
    .i_stat_programmed(prog), .i_stat_select(sel), .o_buf_full(full), .o_buf_empty(empty),
    .o_dout(dout), .o_stat(stat), .o_pixel_clock(pclk), .o_locked(locked));

  dop_app_model dop_app_model_i (.i_dout(dout), .o_read_clock(rd_clk),
    .o_read_reset(rd_rst), .o_transport_drive(tp_drv), .o_video_drive(vp_drv),
    .o_taken(taken));

  // ***************************************************************
  // Clock, helpers and verdict
  // ***************************************************************
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  task automatic settle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic wrap_up;
  begin
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset;
  begin
    check({locked, pclk, stat, empty, full, tp_oe, vp_oe}, 12'h008);
    check(dout, 12'h000);
  end
  endtask
  // Manual lock sources: {tp, vp, tlock, vlock, rlock, expected lock}
  task automatic t_lock_manual;
    logic [5:0] tbl [6];
  begin
    tbl = '{6'b000011, 6'b001100, 6'b110110, 6'b111001, 6'b011010, 6'b010101};
    src = 6'h3F;
    foreach (tbl[k])
    begin
      {tlock, vlock, rlock} = tbl[k][3:1];
      dop_app_model_i.set_pins(tbl[k][5], tbl[k][4]);
      settle(6);
      check(locked, tbl[k][0]);
      check(tp_oe, 1'b0);
      if (!tbl[k][5])
        check(stat, {4{tbl[k][0]}});
    end
  end
  endtask
  task automatic t_auto;
  begin
    dop_app_model_i.set_pins(1'b0, 1'b0);
    auto_sel = 1'b1;
    {tlock, vlock, rlock} = 3'b100;
    settle(6);
    check({tp_oe, vp_oe, tp_wire, vp_wire, locked}, 12'h01D);
    {tlock, vlock} = 2'b01;
    settle(6);
    check({tp_oe, vp_oe, tp_wire, vp_wire, locked}, 12'h01B);
    vlock = 1'b0;
    settle(6);
    check({tp_oe, vp_oe, tp_wire, vp_wire, locked}, 12'h018);
    auto_sel = 1'b0;
  end
  endtask
  // Buffer is still empty here, so the empty flag is a known source
  task automatic t_status;
  begin
    {tlock, vlock, rlock} = 3'b001;
    src = 6'h01;
    settle(6);
    check(stat, 12'h001);
    src = 6'h10;
    settle(3);
    check(stat, 12'h008);
    prog = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      sel = {4{c[2:0]}};
      src = (c < 6) ? 6'(1 << c) : 6'h00;
      settle(3);
      check(stat, (c == 6) ? 12'h000 : 12'h00F);
    end
    sel = {DOP_SRC_F, DOP_SRC_V, DOP_SRC_H, DOP_SRC_LOAD};
    src = 6'h02;
    settle(3);
    check(stat, 12'h004);
    prog = 1'b0;
  end
  endtask
  task automatic t_bypass;
  begin
    pix = 10'h201;
    rec_clk = 1'b1;
    settle(6);
    check(pclk, 1'b1);
    check(dout, 12'h201);
    pix = 10'h3FE;
    settle(6);
    check(dout, 12'h201);
    rec_clk = 1'b0;
    settle(6);
    check(pclk, 1'b0);
    rec_clk = 1'b1;
    settle(6);
    check(dout, 12'h3FE);
    rlock = 1'b0;
    settle(4);
    check({dout, pclk}, 12'h000);
    rec_clk = 1'b0;
  end
  endtask
  // Fill until full, read, clear the read side, then show the clear refused
  task automatic t_buffer;
  begin
    dop_app_model_i.set_pins(1'b0, 1'b1);
    {tlock, vlock, rlock} = 3'b010;
    fen = 1'b1;
    fmode = DOP_FMODE_VIDEO;
    wr_en = 1'b1;
    for (int k = 0; k < DOP_DEPTH; k++)
    begin
      wr_data = 10'h200 | 10'(k);
      settle(1);
    end
    wr_en = 1'b0;
    settle(4);
    check({full, empty}, 12'h002);
    dop_app_model_i.read_edge(1'b0);
    check(dout, 12'h200);
    dop_app_model_i.read_edge(1'b0);
    check(dout, 12'h201);
    check(taken, 12'h200);
    dop_app_model_i.read_edge(1'b1);
    dop_app_model_i.read_edge(1'b0);
    dop_app_model_i.read_edge(1'b0);
    check(dout, 12'h200);
    fmode = DOP_FMODE_ASI;
    src = 6'h20;
    settle(4);
    check(stat[3], 1'b1);
    dop_app_model_i.read_edge(1'b1);
    dop_app_model_i.read_edge(1'b0);
    check(dout, 12'h202);
    dop_app_model_i.read_edge(1'b0);
    check(dout, 12'h203);
  end
  endtask
  // Ancillary mode defaults and pixel path, then a reset in mid-run
  task automatic t_anc_reset;
  begin
    fmode = DOP_FMODE_ANC;
    src = 6'h12;
    pix = 10'h155;
    rec_clk = 1'b1;
    settle(6);
    check(stat, 12'h006);
    check(dout, 12'h155);
    rec_clk = 1'b0;
    i_reset_n = 1'b0;
    settle(2);
    check({locked, pclk, stat, empty, full, tp_oe, vp_oe}, 12'h008);
    check(dout, 12'h000);
    i_reset_n = 1'b1;
    settle(6);
    check(locked, 1'b1);
  end
  endtask

  // ***************************************************************
  // Main sequence and hang guard
  // ***************************************************************
  initial
  begin
    fails = 0;
    tests_run = 0;
    {i_reset_n, auto_sel, fen, rec_clk, vlock, tlock, rlock, wr_en, prog} = '0;
    {fmode, pix, wr_data, src, sel} = '0;
    settle(6);
    t_reset();
    i_reset_n = 1'b1;
    settle(4);
    t_lock_manual();
    t_auto();
    t_status();
    t_bypass();
    t_buffer();
    t_anc_reset();
    wrap_up();
  end
  initial
  begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule
